// *** pkg/sdci_pkg.sv ***
// Shared constants and types for the command decoder and its controller
package sdci_pkg;
  localparam int unsigned BANKS       = 4;
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned PAUSE_US    = 200;
  localparam int unsigned PAUSE_CYC   = (PAUSE_US * 1000) / CLK_NS;
  localparam int unsigned INIT_REFS   = 8;
  localparam int unsigned TRC_CYC     = 7;
  localparam int unsigned BURST_CYC   = 4;
  localparam int unsigned AUTO_PRE_BIT = 10;
  localparam int unsigned MODE_W      = 13;
  localparam logic [MODE_W-1:0] MODE_VALUE = 13'h0022;

  // Operations decoded from one clock edge
  typedef enum logic [3:0] {
    SDCI_OP_DESELECT, SDCI_OP_NOP, SDCI_OP_ACTIVATE, SDCI_OP_PRECHARGE,
    SDCI_OP_PRECHARGE_ALL, SDCI_OP_WRITE, SDCI_OP_READ, SDCI_OP_MODE_SET,
    SDCI_OP_BURST_STOP, SDCI_OP_AUTO_REFRESH, SDCI_OP_SELF_REFRESH,
    SDCI_OP_POWER_DOWN, SDCI_OP_SUSPEND, SDCI_OP_EXIT, SDCI_OP_ILLEGAL
  } sdci_op_e;

  // Strobe pattern {row, column, write enable}
  localparam logic [2:0] PAT_ACT  = 3'h3;
  localparam logic [2:0] PAT_PRE  = 3'h2;
  localparam logic [2:0] PAT_WR   = 3'h4;
  localparam logic [2:0] PAT_RD   = 3'h5;
  localparam logic [2:0] PAT_MRS  = 3'h0;
  localparam logic [2:0] PAT_NOP  = 3'h7;
  localparam logic [2:0] PAT_BST  = 3'h6;
  localparam logic [2:0] PAT_REF  = 3'h1;
endpackage

// *** pkg/sdci_bus_if.sv ***
// Command and address pins between controller and DRAM decoder
`timescale 1ns/1ps
interface sdci_bus_if;
  import sdci_pkg::*;
  logic                  chipSelectB;
  logic                  rowStrobeB;
  logic                  colStrobeB;
  logic                  writeEnableB;
  logic                  cke;
  logic                  dataMask;
  logic                  bank_select_0;
  logic                  bank_select_1;
  logic [ADDR_W-1:0]     addr;
  modport device (input chipSelectB, rowStrobeB, colStrobeB, writeEnableB, cke, dataMask,
                  bank_select_0, bank_select_1, addr);
  modport ctrl   (output chipSelectB, rowStrobeB, colStrobeB, writeEnableB, cke, dataMask,
                  bank_select_0, bank_select_1, addr);
endinterface

// *** design/sdci_device.sv ***
// DRAM side: command decode, bank state, power-down and clock suspend
`timescale 1ns/1ps
// Summary of operation
// R1: Decode operation from strobes and mask each edge; the mask is sampled only when the previous clock enable was high
// R2: Qualify commands with current and previous clock enable
// R3: Bank checks use addressed bank state
// R4: Clock enable low in burst means suspend
// R5: Strobe patterns map to the command set
// R6: Refresh, power-down, exit and mask decode
// R7: Mode register unusable until explicitly programmed
// R8: Controller holds no-op while powering up
// R9: Controller pauses, then precharges all banks
// R10: Mask and clock enable high during pause
// R11: Mode set follows all-bank precharge
// R12: At least eight auto refreshes at init
// R13: Refreshes before or after mode set
// R14: Banks idle, enable high before mode set
// R15: No-op right after mode set
// R16: Row cycle time after each auto refresh
module sdci_device
  import sdci_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rst_b,
  // Pins from the controller
  sdci_bus_if.device          bus,
  // Decoded state
  output logic [3:0]          lastOp_q,
  output logic                opValid_q,
  output logic                illegal_q,
  output logic [BANKS-1:0]    bankActive_q,
  output logic                modeValid_q,
  output logic [MODE_W-1:0]   modeReg_q,
  output logic                selfRefresh_q,
  output logic                powerDown_q,
  output logic                suspend_q,
  output logic                dataEnable_q,
  output logic                burst_q
);

  logic                 ckePrev_q;
  logic [2:0]           burstCnt_q;
  logic [1:0]           bank;
  logic [2:0]           pat;
  logic                 autoPre;
  logic                 accessOk;
  logic                 autoPrePending_q;
  logic [1:0]           autoPreBank_q;
  logic                 sleeping;
  sdci_op_e             op;

  assign bank     = {bus.bank_select_1, bus.bank_select_0}; // R3
  assign pat      = {bus.rowStrobeB, bus.colStrobeB, bus.writeEnableB};
  assign autoPre  = bus.addr[AUTO_PRE_BIT];
  assign sleeping = selfRefresh_q | powerDown_q | suspend_q;

  // Pins are sampled by the decoder as synchronous inputs of this clock
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      ckePrev_q <= 1'b1;
    else
      ckePrev_q <= bus.cke; // R2

  always_comb
  begin
    op = SDCI_OP_ILLEGAL;
    if (!ckePrev_q)
    begin
      // Exit needs deselect or no-op-like strobes, except from suspend, which exits on any strobes
      if (bus.cke && (bus.chipSelectB || (bus.rowStrobeB && bus.colStrobeB)))
        op = SDCI_OP_EXIT; // R6
      else if (bus.cke && suspend_q)
        op = SDCI_OP_EXIT; // R6
      else
        op = SDCI_OP_NOP;
    end
    else if (!bus.cke && burst_q)
      op = SDCI_OP_SUSPEND; // R4
    else if (!bus.cke && !bus.chipSelectB && pat == PAT_REF)
      op = SDCI_OP_SELF_REFRESH; // R6
    else if (!bus.cke && (bus.chipSelectB || pat == PAT_NOP))
      op = SDCI_OP_POWER_DOWN; // R6
    else if (!bus.cke)
      op = SDCI_OP_ILLEGAL;
    else if (bus.chipSelectB)
      op = SDCI_OP_DESELECT;
    else
    begin
      case (pat) // R5
        PAT_ACT: op = SDCI_OP_ACTIVATE;
        PAT_PRE: op = autoPre ? SDCI_OP_PRECHARGE_ALL : SDCI_OP_PRECHARGE;
        PAT_WR:  op = SDCI_OP_WRITE;
        PAT_RD:  op = SDCI_OP_READ;
        PAT_MRS: op = SDCI_OP_MODE_SET;
        PAT_NOP: op = SDCI_OP_NOP;
        PAT_BST: op = SDCI_OP_BURST_STOP;
        PAT_REF: op = SDCI_OP_AUTO_REFRESH;
        default: op = SDCI_OP_ILLEGAL;
      endcase
    end
  end

  // Checks bank state; refused commands only raise the illegal flag
  function automatic logic op_legal(input sdci_op_e o, input logic [BANKS-1:0] act,
                                    input logic [1:0] b, input logic mv);
    case (o)
      SDCI_OP_ACTIVATE:     op_legal = mv && !act[b]; // R3 R7
      SDCI_OP_READ,
      SDCI_OP_WRITE:        op_legal = mv && act[b]; // R3 R7
      SDCI_OP_MODE_SET,
      SDCI_OP_AUTO_REFRESH,
      SDCI_OP_SELF_REFRESH: op_legal = (act == '0);
      default:              op_legal = 1'b1;
    endcase
  endfunction

  // Only an accepted read or write starts a burst
  assign accessOk = (op == SDCI_OP_READ || op == SDCI_OP_WRITE) &&
                    op_legal(op, bankActive_q, bank, modeValid_q); // R3

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      lastOp_q  <= 4'h0;
      opValid_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else
    begin
      lastOp_q  <= op; // R1
      opValid_q <= !suspend_q || op == SDCI_OP_EXIT;
      illegal_q <= (op == SDCI_OP_ILLEGAL) || !op_legal(op, bankActive_q, bank, modeValid_q);
    end

  // Bank state; frozen while clock is suspended
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      bankActive_q <= '0;
    else if (!suspend_q)
    begin
      if (op_legal(op, bankActive_q, bank, modeValid_q))
      begin
        if (op == SDCI_OP_ACTIVATE)
          bankActive_q[bank] <= 1'b1; // R3
        else if (op == SDCI_OP_PRECHARGE)
          bankActive_q[bank] <= 1'b0; // R3
        else if (op == SDCI_OP_PRECHARGE_ALL)
          bankActive_q <= '0;
      end
      // Placed last so the close of an auto-precharge bank always lands
      if (autoPrePending_q && (burstCnt_q <= 3'h1 || accessOk))
        bankActive_q[autoPreBank_q] <= 1'b0; // R5
    end

  // Auto-precharge bank is held until its burst runs out or another burst cuts it
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      autoPrePending_q <= 1'b0;
      autoPreBank_q    <= 2'h0;
    end
    else if (!suspend_q)
    begin
      if (accessOk)
      begin
        autoPrePending_q <= autoPre; // R5
        autoPreBank_q    <= bank;
      end
      else if (burstCnt_q <= 3'h1)
        autoPrePending_q <= 1'b0;
    end

  // Mode register has no trusted value until a mode set lands
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      modeValid_q <= 1'b0; // R7
      modeReg_q   <= '0;
    end
    else if (op == SDCI_OP_MODE_SET && op_legal(op, bankActive_q, bank, modeValid_q))
    begin
      modeValid_q <= 1'b1; // R7
      modeReg_q   <= bus.addr;
    end

  // Burst tracker decides suspend versus power-down
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      burstCnt_q <= 3'h0;
    else if (suspend_q)
      burstCnt_q <= burstCnt_q; // R4
    else if (accessOk)
      burstCnt_q <= 3'(BURST_CYC);
    else if (op == SDCI_OP_BURST_STOP || op == SDCI_OP_PRECHARGE_ALL)
      burstCnt_q <= 3'h0;
    else if (burstCnt_q != 3'h0)
      burstCnt_q <= burstCnt_q - 3'h1;

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      burst_q <= 1'b0;
    else
      burst_q <= (burstCnt_q > 3'h1) ||
                 (accessOk && !suspend_q) ||
                 (suspend_q && burst_q);

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      selfRefresh_q <= 1'b0;
      powerDown_q   <= 1'b0;
      suspend_q     <= 1'b0;
    end
    else if (op == SDCI_OP_EXIT)
    begin
      selfRefresh_q <= 1'b0; // R6
      powerDown_q   <= 1'b0;
      suspend_q     <= 1'b0; // R4
    end
    else if (!sleeping)
    begin
      selfRefresh_q <= op == SDCI_OP_SELF_REFRESH && op_legal(op, bankActive_q, bank,
                       modeValid_q);
      powerDown_q   <= op == SDCI_OP_POWER_DOWN; // R4
      suspend_q     <= op == SDCI_OP_SUSPEND; // R4
    end

  // Mask high blocks write data and output
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      dataEnable_q <= 1'b0;
    else if (ckePrev_q)
      dataEnable_q <= !bus.dataMask; // R6 R1

endmodule // sdci_device

// *** design/sdci_ctrl.sv ***
// Controller side: power-up sequence and user command issue
`timescale 1ns/1ps
module sdci_ctrl
  import sdci_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = PAUSE_CYC
)
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // User command port
  input  wire logic                 cmdValid,
  input  wire logic [2:0]           cmdPat,
  input  wire logic [1:0]           cmdBank,
  input  wire logic [ADDR_W-1:0]    cmdAddr,
  input  wire logic                 cmdCke,
  input  wire logic                 cmdMask,
  output logic                      cmdReady_q,
  output logic                      initDone_q,
  // Pins to the device
  sdci_bus_if.ctrl                  bus
);

  typedef enum {ST_PAUSE, ST_PRE_ALL, ST_MRS, ST_MRS_NOP, ST_REF, ST_REF_WAIT, ST_RUN}
    sdci_state_e;

  sdci_state_e   state_q;
  logic [31:0]   cnt_q;
  logic [3:0]    refs_q;
  logic          csB_q, rasB_q, casB_q, weB_q, cke_q, dqm_q, bankSelect0_q, bankSelect1_q;
  logic [ADDR_W-1:0] addr_q;

  assign bus.chipSelectB   = csB_q;
  assign bus.rowStrobeB    = rasB_q;
  assign bus.colStrobeB    = casB_q;
  assign bus.writeEnableB  = weB_q;
  assign bus.cke           = cke_q;
  assign bus.dataMask      = dqm_q;
  assign bus.bank_select_0 = bankSelect0_q;
  assign bus.bank_select_1 = bankSelect1_q;
  assign bus.addr          = addr_q;

  // Sequence: pause, precharge all, mode set, no-op, eight refreshes
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      state_q <= ST_PAUSE;
      cnt_q   <= '0;
      refs_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_PAUSE:
          if (cnt_q >= PAUSE_CYCLES - 1) // R9
          begin
            state_q <= ST_PRE_ALL;
            cnt_q   <= '0;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        ST_PRE_ALL: state_q <= ST_MRS; // R9 R11 R14
        ST_MRS:     state_q <= ST_MRS_NOP; // R11
        ST_MRS_NOP: state_q <= ST_REF; // R15 R13
        ST_REF:
        begin
          state_q <= ST_REF_WAIT;
          refs_q  <= refs_q + 4'h1; // R12
          cnt_q   <= '0;
        end
        ST_REF_WAIT:
          if (cnt_q >= TRC_CYC - 1) // R16
            state_q <= (refs_q >= 4'(INIT_REFS)) ? ST_RUN : ST_REF; // R12
          else
            cnt_q <= cnt_q + 32'h1;
        ST_RUN:     state_q <= ST_RUN;
        default:    state_q <= ST_PAUSE;
      endcase
    end

  // Pin drive; mask and enable high until running, no-op except the precharge-all, mode set and refresh states
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      {csB_q, rasB_q, casB_q, weB_q} <= {1'b0, PAT_NOP}; // R8
      cke_q  <= 1'b1; // R10
      dqm_q  <= 1'b1; // R10
      bankSelect0_q <= 1'b0;
      bankSelect1_q <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      cke_q <= 1'b1;
      dqm_q <= 1'b1;
      bankSelect0_q <= 1'b0;
      bankSelect1_q <= 1'b0;
      addr_q <= '0;
      {csB_q, rasB_q, casB_q, weB_q} <= {1'b0, PAT_NOP};
      case (state_q)
        ST_PRE_ALL:
        begin
          {rasB_q, casB_q, weB_q} <= PAT_PRE; // R9
          addr_q[AUTO_PRE_BIT]    <= 1'b1;
        end
        ST_MRS:
        begin
          {rasB_q, casB_q, weB_q} <= PAT_MRS; // R11
          addr_q                  <= MODE_VALUE;
        end
        ST_REF:     {rasB_q, casB_q, weB_q} <= PAT_REF; // R12
        ST_RUN:
        begin
          cke_q <= cmdCke;
          dqm_q <= cmdMask;
          if (cmdValid)
          begin
            {rasB_q, casB_q, weB_q} <= cmdPat;
            {bankSelect1_q, bankSelect0_q} <= cmdBank;
            addr_q                  <= cmdAddr;
          end
        end
        default: csB_q <= 1'b0;
      endcase
    end

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      cmdReady_q <= 1'b0;
      initDone_q <= 1'b0;
    end
    else
    begin
      cmdReady_q <= state_q == ST_RUN;
      initDone_q <= state_q == ST_RUN;
    end

endmodule // sdci_ctrl

// *** testbench/sdci_monitor.sv ***
// Pin-level checker for the power-up sequence and command spacing
`timescale 1ns/1ps
module sdci_monitor
  import sdci_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = PAUSE_CYC
)
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_b,
  // Command and address pins
  input wire logic              chipSelectB,
  input wire logic              rowStrobeB,
  input wire logic              colStrobeB,
  input wire logic              writeEnableB,
  input wire logic              cke,
  input wire logic              dataMask,
  input wire logic              bank_select_0,
  input wire logic              bank_select_1,
  input wire logic [ADDR_W-1:0] addr
);
  logic [2:0]  pat;
  logic        isNop;
  logic        isMrs;
  logic        isRef;
  logic        isAcc;
  logic        isPreAll;
  logic [15:0] cycCnt_q;
  logic [3:0]  refCnt_q;
  logic [3:0]  gap_q;
  logic        preSeen_q;
  logic        mrsSeen_q;
  logic        anySeen_q;

  assign pat      = {rowStrobeB, colStrobeB, writeEnableB};
  assign isNop    = chipSelectB || pat == PAT_NOP;
  assign isMrs    = !chipSelectB && pat == PAT_MRS;
  assign isRef    = !chipSelectB && pat == PAT_REF;
  assign isAcc    = !chipSelectB && (pat == PAT_ACT || pat == PAT_RD || pat == PAT_WR);
  assign isPreAll = !chipSelectB && pat == PAT_PRE && addr[AUTO_PRE_BIT];

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      cycCnt_q <= 16'h0000;
    else if (cycCnt_q != 16'hffff)
      cycCnt_q <= cycCnt_q + 16'h0001;

  // Saturating counts keep long runs from wrapping into false passes
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      refCnt_q <= 4'h0;
    else if (isRef && refCnt_q != 4'hf)
      refCnt_q <= refCnt_q + 4'h1;

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      gap_q <= 4'hf;
    else if (isRef)
      gap_q <= 4'h1;
    else if (gap_q != 4'hf)
      gap_q <= gap_q + 4'h1;

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      preSeen_q <= 1'b0;
    else if (isPreAll)
      preSeen_q <= 1'b1;
    else if (isAcc)
      preSeen_q <= 1'b0;

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      mrsSeen_q <= 1'b0;
    else if (isMrs)
      mrsSeen_q <= 1'b1;

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      anySeen_q <= 1'b0;
    else if (!isNop)
      anySeen_q <= 1'b1;

  pause_nop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cycCnt_q < PAUSE_CYCLES |-> !chipSelectB && pat == PAT_NOP)
    else $error("command issued during power-up pause");
  pause_pins_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cycCnt_q < PAUSE_CYCLES |-> cke && dataMask)
    else $error("mask or clock enable low during pause");
  first_cmd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !anySeen_q && !isNop |-> isPreAll && cycCnt_q >= PAUSE_CYCLES)
    else $error("first command is not a timely precharge-all");
  mrs_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
    isMrs |-> preSeen_q)
    else $error("mode set without all banks precharged");
  mrs_cke_a: assert property (@(posedge mclk) disable iff (!rst_b)
    isMrs |-> cke && $past(cke))
    else $error("clock enable not high before mode set");
  mrs_then_nop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    isMrs |=> isNop)
    else $error("mode set not followed by no-op");
  init_refs_a: assert property (@(posedge mclk) disable iff (!rst_b)
    isAcc |-> refCnt_q >= INIT_REFS && mrsSeen_q)
    else $error("access before init refreshes and mode set");
  ref_gap_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (isRef || isAcc) && refCnt_q != 4'h0 |-> gap_q >= TRC_CYC)
    else $error("refresh spacing too short");
endmodule // sdci_monitor

// *** testbench/tb.sv ***
// Bench joining controller and device, driving the user port with directed commands and random banks, addresses and masks
`timescale 1ns/1ps
module tb;
  import sdci_pkg::*;
  localparam int unsigned PSIM = 10;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic              cmdValid = 1'b0;
  logic [2:0]        cmdPat = PAT_NOP;
  logic [1:0]        cmdBank = 2'h0;
  logic [ADDR_W-1:0] cmdAddr = 13'h0000;
  logic              cmdCke = 1'b1;
  logic              cmdMask = 1'b1;
  logic              cmdReady_q, initDone_q, opValid_q, illegal_q, modeValid_q;
  logic              selfRefresh_q, powerDown_q, suspend_q, dataEnable_q, burst_q;
  logic [3:0]        lastOp_q;
  logic [BANKS-1:0]  bankActive_q;
  logic [MODE_W-1:0] modeReg_q;
  logic [31:0]       seed = 32'h85f81f24;
  logic [31:0]       r;
  logic [2:0]        p;
  int                nFail = 0;
  int                samplesChecked = 0;

  always #50 mclk = ~mclk;

  sdci_bus_if bus ();
  sdci_ctrl #(.PAUSE_CYCLES(PSIM)) i_sdci_ctrl (.mclk(mclk), .rst_b(rst_b),
    .cmdValid(cmdValid), .cmdPat(cmdPat), .cmdBank(cmdBank), .cmdAddr(cmdAddr),
    .cmdCke(cmdCke), .cmdMask(cmdMask), .cmdReady_q(cmdReady_q),
    .initDone_q(initDone_q), .bus(bus));
  sdci_device i_sdci_device (.mclk(mclk), .rst_b(rst_b), .bus(bus), .lastOp_q(lastOp_q),
    .opValid_q(opValid_q), .illegal_q(illegal_q), .bankActive_q(bankActive_q),
    .modeValid_q(modeValid_q), .modeReg_q(modeReg_q), .selfRefresh_q(selfRefresh_q),
    .powerDown_q(powerDown_q), .suspend_q(suspend_q), .dataEnable_q(dataEnable_q),
    .burst_q(burst_q));
  sdci_monitor #(.PAUSE_CYCLES(PSIM)) i_sdci_monitor (.mclk(mclk), .rst_b(rst_b),
    .chipSelectB(bus.chipSelectB), .rowStrobeB(bus.rowStrobeB),
    .colStrobeB(bus.colStrobeB), .writeEnableB(bus.writeEnableB), .cke(bus.cke),
    .dataMask(bus.dataMask), .bank_select_0(bus.bank_select_0),
    .bank_select_1(bus.bank_select_1), .addr(bus.addr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic sdci_op_e exp_op(input logic [2:0] pt, input logic autoPre);
    case (pt)
      PAT_ACT: return SDCI_OP_ACTIVATE;
      PAT_PRE: return autoPre ? SDCI_OP_PRECHARGE_ALL : SDCI_OP_PRECHARGE;
      PAT_WR:  return SDCI_OP_WRITE;
      PAT_RD:  return SDCI_OP_READ;
      PAT_MRS: return SDCI_OP_MODE_SET;
      PAT_BST: return SDCI_OP_BURST_STOP;
      PAT_REF: return SDCI_OP_AUTO_REFRESH;
      default: return SDCI_OP_NOP;
    endcase
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nFail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One command per call; ends just after the edge that takes it
  task automatic drive(input logic [2:0] pt, input logic [1:0] b, input logic [12:0] a,
                       input logic ck, input logic m);
    cmdValid = 1'b1;
    cmdPat = pt;
    cmdBank = b;
    cmdAddr = a;
    cmdCke = ck;
    cmdMask = m;
    @(posedge mclk);
    #1;
  endtask

  // Lets the device sample the last command before outputs are read
  task automatic settle();
    cmdValid = 1'b0;
    cmdCke = 1'b1;
    @(posedge mclk);
    #1;
  endtask

  initial
  begin
    #(20000 * 100);
    nFail++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 400 && cmdReady_q !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    chk(cmdReady_q, 1'b1);
    chk(initDone_q, 1'b1);
    chk(modeValid_q, 1'b1);
    chk(modeReg_q, MODE_VALUE);
    $display("init sequence done");
    for (int b = 0; b < BANKS; b++)
    begin
      r = rnd();
      drive(PAT_ACT, b[1:0], r[12:0], 1'b1, 1'b1);
      settle();
      chk(lastOp_q, exp_op(PAT_ACT, 1'b0));
      chk(bankActive_q[b], 1'b1);
    end
    drive(PAT_ACT, 2'h2, 13'h0000, 1'b1, 1'b1);
    settle();
    chk(illegal_q, 1'b1);
    chk(bankActive_q, 4'hf);
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      p = r[0] ? PAT_RD : PAT_WR;
      drive(p, r[2:1], {3'h0, r[12:3]}, 1'b1, r[13]);
      settle();
      chk(lastOp_q, exp_op(p, 1'b0));
      chk(burst_q, 1'b1);
      chk(dataEnable_q, !r[13]);
      repeat (4) @(posedge mclk);
      #1;
    end
    $display("access test done");
    drive(PAT_RD, 2'h0, 13'h0000, 1'b1, 1'b0);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b0, 1'b0);
    chk(suspend_q, 1'b1);
    chk(powerDown_q, 1'b0);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b1, 1'b1);
    chk(opValid_q, 1'b0);
    settle();
    chk(suspend_q, 1'b0);
    chk(opValid_q, 1'b1);
    repeat (6) @(posedge mclk);
    #1;
    drive(PAT_PRE, 2'h1, 13'h0000, 1'b1, 1'b1);
    settle();
    chk(lastOp_q, exp_op(PAT_PRE, 1'b0));
    chk(bankActive_q, 4'hd);
    // Read with auto-precharge: bank stays open through the burst, then closes
    drive(PAT_RD, 2'h3, 13'h0400, 1'b1, 1'b1);
    settle();
    chk(lastOp_q, exp_op(PAT_RD, 1'b1));
    repeat (3) @(posedge mclk);
    #1;
    chk(bankActive_q, 4'hd);
    @(posedge mclk);
    #1;
    chk(bankActive_q, 4'h5);
    drive(PAT_RD, 2'h1, 13'h0000, 1'b1, 1'b1);
    settle();
    chk(illegal_q, 1'b1);
    chk(burst_q, 1'b0);
    drive(PAT_PRE, 2'h0, 13'h0400, 1'b1, 1'b1);
    drive(PAT_BST, 2'h0, 13'h0000, 1'b1, 1'b1);
    chk(lastOp_q, exp_op(PAT_PRE, 1'b1));
    settle();
    chk(lastOp_q, exp_op(PAT_BST, 1'b0));
    chk(bankActive_q, 4'h0);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk(powerDown_q, 1'b1);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b1, 1'b1);
    settle();
    chk(powerDown_q, 1'b0);
    drive(PAT_REF, 2'h0, 13'h0000, 1'b0, 1'b1);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b0, 1'b1);
    chk(selfRefresh_q, 1'b1);
    drive(PAT_NOP, 2'h0, 13'h0000, 1'b1, 1'b1);
    settle();
    chk(selfRefresh_q, 1'b0);
    repeat (8) @(posedge mclk);
    #1;
    drive(PAT_REF, 2'h0, 13'h0000, 1'b1, 1'b1);
    settle();
    chk(lastOp_q, exp_op(PAT_REF, 1'b0));
    repeat (8) @(posedge mclk);
    #1;
    $display("power and refresh test done");
    r = rnd();
    drive(PAT_MRS, 2'h0, r[12:0], 1'b1, 1'b1);
    settle();
    chk(lastOp_q, exp_op(PAT_MRS, 1'b0));
    chk(modeReg_q, r[12:0]);
    $display("mode set test done");
    give_verdict();
  end
endmodule // tb
